// [fts_pkg.sv]
// Package for the fan tach mode and spin-up control block.
// Assumes one clock domain and a byte-wide register port from the serial slave.
// Functional notes
// - Addresses 70h to 7Fh are vendor space; values there undefined after power-up.
// - Tach mode register holds three 2-bit selects: input one, two, three/four.
// - Four modes with low PWM range; only mode 0 with high range.
// - Reported speed always assumes two tach pulses per revolution.
// - Mode 00 is plain detection; under-range readings may be spurious.
// - Mode 01 is plain detection; under-range reports FFFFh.
// - Mode 10 uses extended low-speed circuitry for accuracy; under-range FFFFh.
// - Mode 11 uses extended low-speed, least PWM disturbance; under-range FFFFh.
// - Minimum speed depends on PWM frequency; 841 RPM or 210 to 420 RPM.
// - Tach mode stays writable under lock; default 00h used while start clear.
// - Spin-up register holds three early-stop enables, reset 7h; clear means full time.
// - Enabled early stop ends spin-up on tach past limit or timeout, whichever first.
// - Spin-up register ignores writes once locked; default used while start clear.
// - Undefined addresses read 00h; writes there do nothing and raise no error.
// - Setting bit 0 of test register 6Fh enters XOR-tree test mode.
// - XOR tree leaves out the serial pins; chaining order is free.
// - Writing zero to the XOR-tree enable leaves test mode.
package fts_pkg;
  localparam logic [7:0] ADDR_TEST       = 8'h6f;
  localparam logic [7:0] ADDR_TACH_MODE  = 8'h74;
  localparam logic [7:0] ADDR_SPINUP     = 8'h75;
  localparam logic [7:0] TACH_MODE_RESET = 8'h00;
  localparam logic [2:0] SPINUP_RESET    = 3'h7;
  localparam logic [7:0] TEST_RESET      = 8'h00;
  localparam logic [7:0] TACH_MODE_MASK  = 8'h3f;
  localparam logic [7:0] SPINUP_MASK     = 8'h07;
  localparam logic [7:0] TEST_MASK       = 8'h01;
  localparam logic [15:0] COUNT_SAT      = 16'hffff;
  localparam logic [15:0] SAT_FLOOR      = 16'h8000;
  localparam int         PULSES_PER_REV  = 2;

  // Tach measurement modes.
  typedef enum logic [1:0] {
    FTS_MODE_PLAIN     = 2'h0,
    FTS_MODE_PLAIN_SAT = 2'h1,
    FTS_MODE_ACCURATE  = 2'h2,
    FTS_MODE_GENTLE    = 2'h3
  } fts_mode_e;

  // Register access carried from the serial slave.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fts_reg_req_s;

  // Spin-up control for one drive output.
  typedef struct packed {
    logic        start;
    logic [15:0] time_cycles;
    logic [15:0] tach_limit;
  } fts_spin_cfg_s;
endpackage

// [fts_tach_meas.sv]
// Tachometer period counter for one fan input.
// Assumes tach input synchronous to mclk; pwm_on marks drive-on phase.
`timescale 1ns/100ps
module fts_tach_meas #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Configuration.
  input  wire fts_pkg::fts_mode_e mode,
  input  wire logic             high_freq,
  // Fan signals.
  input  wire logic             tach,
  input  wire logic             pwm_on,
  input  wire logic [WIDTH-1:0] min_limit,
  // Result.
  output logic [WIDTH-1:0]      count,
  output logic                  valid
);
  logic             tach_q;
  logic [WIDTH-1:0] run;
  logic [1:0]       edges;
  logic             rise;
  logic             over;
  logic             comp;
  logic             hold;
  fts_pkg::fts_mode_e eff;

  // High PWM range forces plain mode; compensation pauses counting off-phase.
  assign eff  = high_freq ? fts_pkg::FTS_MODE_PLAIN : mode;
  assign comp = (eff == fts_pkg::FTS_MODE_ACCURATE) ||
                (eff == fts_pkg::FTS_MODE_GENTLE);
  assign hold = comp && !pwm_on;
  assign rise = tach && !tach_q;
  assign over = (run >= min_limit);

  // Edge detector on the tach input. It resets to the pulled-up idle level,
  // so that a stopped fan does not show a false edge after reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tach_q <= 1'b1;
    end else begin
      tach_q <= tach;
    end
  end

  // Count across two pulses, one revolution.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run   <= '0;
      edges <= 2'h0;
      count <= fts_pkg::COUNT_SAT;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (rise && edges == 2'(fts_pkg::PULSES_PER_REV)) begin
        count <= run;
        valid <= 1'b1;
        run   <= '0;
        edges <= 2'h1;
      end else if (rise) begin
        edges <= edges + 2'h1;
      end else if (over && eff != fts_pkg::FTS_MODE_PLAIN) begin
        count <= fts_pkg::COUNT_SAT;
        valid <= 1'b1;
        run   <= '0;
        edges <= 2'h1;
      end else if (over) begin
        run <= '0;
      end else if (!hold && edges != 2'h0) begin
        run <= run + 1'b1;
      end
    end
  end
endmodule

// [fts_spinup.sv]
// Spin-up timer for one fan drive output.
// Assumes start is a one-cycle pulse from the drive logic.
`timescale 1ns/100ps
module fts_spinup (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Control.
  input  wire fts_pkg::fts_spin_cfg_s cfg,
  input  wire logic                   early_en,
  input  wire logic [15:0]            tach_count,
  input  wire logic                   tach_valid,
  // Status.
  output logic                        spinning
);
  typedef enum logic [1:0] {
    FTS_IDLE = 2'b01,
    FTS_SPIN = 2'b10
  } fts_spin_e;
  fts_spin_e   state;
  logic [15:0] left;
  logic        fast;

  // Fan is fast enough when its period is below the limit.
  assign fast = tach_valid && (tach_count < cfg.tach_limit);
  assign spinning = (state == FTS_SPIN);

  // Spin-up sequence.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= FTS_IDLE;
      left  <= 16'h0000;
    end else begin
      unique case (state)
        FTS_IDLE: begin
          if (cfg.start) begin
            state <= FTS_SPIN;
            left  <= cfg.time_cycles;
          end
        end
        FTS_SPIN: begin
          if (left <= 16'h0001) begin
            state <= FTS_IDLE;
          end else if (early_en && fast) begin
            state <= FTS_IDLE;
          end
          left <= left - 16'h0001;
        end
        default: state <= FTS_IDLE;
      endcase
    end
  end
endmodule

// [fts_ctrl.sv]
// Top of the fan tach mode and spin-up control block.
// Assumes the serial slave presents one-cycle byte accesses; lock and start
// come from the lock/start register elsewhere.
`timescale 1ns/100ps
module fts_ctrl (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Register port.
  input  wire fts_pkg::fts_reg_req_s  req,
  output logic [7:0]                  rdata,
  output logic                        rack,
  // Global control.
  input  wire logic                   lock,
  input  wire logic                   start_bit,
  input  wire logic                   high_freq,
  // Fan pins.
  input  wire logic [3:0]             fan_speed_in,
  input  wire logic [2:0]             fan_drive_out,
  // Spin-up control per drive.
  input  wire fts_pkg::fts_spin_cfg_s spin_cfg [3],
  // Results.
  output logic [15:0]                 tach_count [4],
  output logic [3:0]                  tach_valid,
  output logic [2:0]                  spinning,
  // Test mode.
  input  wire logic [7:0]             xor_pins,
  output logic                        xor_tree_enable,
  output logic                        xor_out
);
  logic [7:0] tach_measure_mode;
  logic [2:0] fan_spinup_early_stop;
  logic [7:0] eff_mode;
  logic [2:0] eff_spin;
  logic [1:0] tach_one_mode_sel;
  logic [1:0] tach_two_mode_sel;
  logic [1:0] tach_three_four_mode_sel;
  logic       drive_one_early_stop_en;
  logic       drive_two_early_stop_en;
  logic       drive_three_early_stop_en;
  logic [7:0] next_rdata;
  logic       hit;

  // Tach mode register, writable even under lock.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tach_measure_mode <= fts_pkg::TACH_MODE_RESET;
    end else if (req.wr && req.addr == fts_pkg::ADDR_TACH_MODE) begin
      tach_measure_mode <= req.wdata & fts_pkg::TACH_MODE_MASK;
    end
  end

  // Spin-up register, frozen under lock.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fan_spinup_early_stop <= fts_pkg::SPINUP_RESET;
    end else if (req.wr && !lock && req.addr == fts_pkg::ADDR_SPINUP) begin
      fan_spinup_early_stop <= req.wdata[2:0];
    end
  end

  // Test register, frozen under lock; zero leaves test mode.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      xor_tree_enable <= fts_pkg::TEST_RESET[0];
    end else if (req.wr && !lock && req.addr == fts_pkg::ADDR_TEST) begin
      xor_tree_enable <= req.wdata[0];
    end
  end

  // Defaults apply while start is clear.
  assign eff_mode = start_bit ? tach_measure_mode
                              : fts_pkg::TACH_MODE_RESET;
  assign eff_spin = start_bit ? fan_spinup_early_stop
                              : fts_pkg::SPINUP_RESET;
  assign tach_one_mode_sel        = eff_mode[1:0];
  assign tach_two_mode_sel        = eff_mode[3:2];
  assign tach_three_four_mode_sel = eff_mode[5:4];
  assign drive_one_early_stop_en   = eff_spin[0];
  assign drive_two_early_stop_en   = eff_spin[1];
  assign drive_three_early_stop_en = eff_spin[2];

  // Read decode; unknown addresses read zero and 70h-7Fh others too.
  always_comb begin
    next_rdata = 8'h00;
    hit        = 1'b1;
    unique case (req.addr)
      fts_pkg::ADDR_TACH_MODE: next_rdata = tach_measure_mode;
      fts_pkg::ADDR_SPINUP:
        next_rdata = {5'h00, fan_spinup_early_stop} & fts_pkg::SPINUP_MASK;
      fts_pkg::ADDR_TEST:
        next_rdata = {7'h00, xor_tree_enable} & fts_pkg::TEST_MASK;
      default: hit = 1'b0;
    endcase
  end

  // Read data register; every access is acknowledged, never an error.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rack  <= 1'b0;
    end else begin
      rack <= req.rd || req.wr;
      if (req.rd) begin
        rdata <= hit ? next_rdata : 8'h00;
      end
    end
  end

  // Tach measurement per input; drive k compensates its own inputs.
  fts_tach_meas u_fan_speed_in_one (
    .mclk(mclk), .nrst(nrst),
    .mode(fts_pkg::fts_mode_e'(tach_one_mode_sel)),
    .high_freq(high_freq), .tach(fan_speed_in[0]),
    .pwm_on(fan_drive_out[0]),
    .min_limit(spin_cfg[0].tach_limit | fts_pkg::SAT_FLOOR),
    .count(tach_count[0]), .valid(tach_valid[0])
  );
  fts_tach_meas u_fan_speed_in_two (
    .mclk(mclk), .nrst(nrst),
    .mode(fts_pkg::fts_mode_e'(tach_two_mode_sel)),
    .high_freq(high_freq), .tach(fan_speed_in[1]),
    .pwm_on(fan_drive_out[1]),
    .min_limit(spin_cfg[1].tach_limit | fts_pkg::SAT_FLOOR),
    .count(tach_count[1]), .valid(tach_valid[1])
  );
  genvar gi;
  generate
    for (gi = 2; gi < 4; gi++) begin : g_tach34
      fts_tach_meas u_tach (
        .mclk(mclk), .nrst(nrst),
        .mode(fts_pkg::fts_mode_e'(tach_three_four_mode_sel)),
        .high_freq(high_freq), .tach(fan_speed_in[gi]),
        .pwm_on(fan_drive_out[2]),
        .min_limit(spin_cfg[2].tach_limit | fts_pkg::SAT_FLOOR),
        .count(tach_count[gi]), .valid(tach_valid[gi])
      );
    end
  endgenerate

  // Spin-up timers; drive three watches input three.
  fts_spinup u_spin1 (
    .mclk(mclk), .nrst(nrst), .cfg(spin_cfg[0]),
    .early_en(drive_one_early_stop_en),
    .tach_count(tach_count[0]), .tach_valid(tach_valid[0]),
    .spinning(spinning[0])
  );
  fts_spinup u_spin2 (
    .mclk(mclk), .nrst(nrst), .cfg(spin_cfg[1]),
    .early_en(drive_two_early_stop_en),
    .tach_count(tach_count[1]), .tach_valid(tach_valid[1]),
    .spinning(spinning[1])
  );
  fts_spinup u_spin3 (
    .mclk(mclk), .nrst(nrst), .cfg(spin_cfg[2]),
    .early_en(drive_three_early_stop_en),
    .tach_count(tach_count[2]), .tach_valid(tach_valid[2]),
    .spinning(spinning[2])
  );

  // XOR tree over non-serial pins; order does not matter.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      xor_out <= 1'b0;
    end else begin
      xor_out <= xor_tree_enable &
                 (^{xor_pins, fan_speed_in, fan_drive_out});
    end
  end
endmodule

// [fts_ctrl_properties.sv]
// Checker for the register port of the fan tach control top.
// Assumes it is bound to fts_ctrl and sees only its ports.
`timescale 1ns/100ps
module fts_ctrl_properties (
  // Clock and reset.
  input wire logic                  mclk,
  input wire logic                  nrst,
  // Register port and test mode.
  input wire fts_pkg::fts_reg_req_s req,
  input wire logic [7:0]            rdata,
  input wire logic                  rack,
  input wire logic                  lock,
  input wire logic                  xor_tree_enable
);
  logic acc;
  logic und;
  logic wt;
  // Access strobe, undefined decode and unlocked test write.
  assign acc = req.wr | req.rd;
  assign und = !(req.addr inside {8'h6f, 8'h74, 8'h75});
  assign wt = req.wr && req.addr == 8'h6f && !lock;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rack_on_access: assert property (acc |=> rack)
    else $error("rack missing");
  a_rack_idle: assert property (!acc |=> !rack)
    else $error("stray rack");
  a_undef_reads_zero: assert property (req.rd && und |=> rdata == 8'h00)
    else $error("undefined read not zero");
  a_mode_res_zero: assert property
    (req.rd && req.addr == 8'h74 |=> rdata[7:6] == 2'h0)
    else $error("tach mode reserved bits set");
  a_spin_res_zero: assert property
    (req.rd && req.addr == 8'h75 |=> rdata[7:3] == 5'h00)
    else $error("spin-up reserved bits set");
  a_xor_enter: assert property (wt && req.wdata[0] |=> xor_tree_enable)
    else $error("test mode not entered");
  a_xor_leave: assert property (wt && !req.wdata[0] |=> !xor_tree_enable)
    else $error("test mode not left");
  a_mode_write_back: assert property
    (req.wr && req.addr == 8'h74 ##1 !acc ##1 req.rd && req.addr == 8'h74
     |=> rdata[5:0] == $past(req.wdata[5:0], 3))
    else $error("tach mode readback wrong");
  // Main scenarios reached.
  c_locked_write: cover property (req.wr && lock);
  c_test_mode: cover property ($rose(xor_tree_enable));
  c_undef_read: cover property (req.rd && und);
endmodule

bind fts_ctrl fts_ctrl_properties u_props (
  .mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata), .rack(rack),
  .lock(lock), .xor_tree_enable(xor_tree_enable));

// [fts_fan_model.sv]
// Model of PWM-driven fans whose tach outputs feed the block.
// Assumes the bench sets run and the tach half period in cycles.
`timescale 1ns/100ps
module fts_fan_model (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Fan speed control.
  input  wire logic        run,
  input  wire logic [15:0] half,
  // Fan pins.
  output logic [3:0]       fan_speed_in,
  output logic [2:0]       fan_drive_out
);
  logic [15:0] cnt;
  logic        tach;
  logic        flip;
  // A spinning fan toggles tach; a stopped one rests at the pull-up level.
  assign flip = cnt == half - 16'h0001;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= 16'h0000;
      tach <= 1'b1;
    end else begin
      cnt  <= (!run || flip) ? 16'h0000 : cnt + 16'h0001;
      tach <= !run | (tach ^ flip);
    end
  end
  // All three drives follow run; all four inputs carry the same tach.
  assign fan_drive_out = {3{run}};
  assign fan_speed_in  = {4{tach}};
endmodule

// [fts_ctrl_bench.sv]
// Testbench for the fan tach mode and spin-up control block.
// Assumes the checker and fan model files are compiled first.
`timescale 1ns/100ps
module fts_ctrl_bench;
  logic                   mclk;
  logic                   nrst;
  fts_pkg::fts_reg_req_s  req;
  logic [7:0]             rdata;
  logic                   rack;
  logic                   lock;
  logic                   start_bit;
  logic                   high_freq;
  logic [3:0]             fan_speed_in;
  logic [2:0]             fan_drive_out;
  fts_pkg::fts_spin_cfg_s spin_cfg [3];
  logic [15:0]            tach_count [4];
  logic [3:0]             tach_valid;
  logic [2:0]             spinning;
  logic [7:0]             xor_pins;
  logic                   xor_tree_enable;
  logic                   xor_out;
  logic                   run;
  int                     errors;
  int                     num_checks;
  int                     n;

  fts_ctrl DUT (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata),
    .rack(rack), .lock(lock), .start_bit(start_bit), .high_freq(high_freq),
    .fan_speed_in(fan_speed_in), .fan_drive_out(fan_drive_out),
    .spin_cfg(spin_cfg), .tach_count(tach_count), .tach_valid(tach_valid),
    .spinning(spinning), .xor_pins(xor_pins),
    .xor_tree_enable(xor_tree_enable), .xor_out(xor_out));
  fts_fan_model u_fan (.mclk(mclk), .nrst(nrst), .run(run),
    .half(16'd10), .fan_speed_in(fan_speed_in),
    .fan_drive_out(fan_drive_out));

  // Free-running clock, 8 ns period.
  always #4 mclk = ~mclk;

  // Counts one comparison and reports a mismatch.
  task automatic chk(input string what, input logic [15:0] e, s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) req <= '0;
    #1;
  endtask

  // One-cycle register read, compared when rack arrives.
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '0;
    #1;
    chk("rack", 16'h0001, {15'h0, rack});
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // Starts spin-up on drive one and judges whether it stopped early.
  task automatic spin(input logic early);
    @(posedge mclk) spin_cfg[0].start <= 1'b1;
    @(posedge mclk) spin_cfg[0].start <= 1'b0;
    @(posedge mclk);
    #1;
    chk("spinning", 16'h0001, {15'h0, spinning[0]});
    chk("spin_others", 16'h0000, {14'h0, spinning[2:1]});
    n = 0;
    while (spinning[0] === 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("spin_early", {15'h0, early}, {15'h0, n < 500});
    if (n >= 3000) begin
      errors++;
      complete_run();
    end
  endtask

  // Waits for a tach result on input one; a timeout counts as a mismatch.
  task automatic wait_valid;
    n = 0;
    while (tach_valid[0] !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 300) begin
      errors++;
      complete_run();
    end
  endtask

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    req = '0;
    lock = 1'b0;
    start_bit = 1'b1;
    high_freq = 1'b0;
    xor_pins = 8'h5b;
    run = 1'b0;
    errors = 0;
    num_checks = 0;
    foreach (spin_cfg[i]) spin_cfg[i] = '{1'b0, 16'd2000, 16'd1000};
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h07);
    rd(8'h6f, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h74, {2'h3, {3{m[1:0]}}});
      rd(8'h74, {2'h0, {3{m[1:0]}}});
    end
    wr(8'h75, 8'hf8);
    rd(8'h75, 8'h00);
    @(posedge mclk) lock <= 1'b1;
    wr(8'h74, 8'h15);
    rd(8'h74, 8'h15);
    wr(8'h75, 8'h07);
    rd(8'h75, 8'h00);
    @(posedge mclk) lock <= 1'b0;
    $display("register test done");
    for (int a = 8'h70; a < 8'h80; a += 3) begin
      wr(a[7:0], 8'hff);
      rd(a[7:0], 8'h00);
    end
    $display("undefined address test done");
    wr(8'h6f, 8'hff);
    chk("xor_en", 16'h0001, {15'h0, xor_tree_enable});
    repeat (3) @(posedge mclk);
    #1;
    chk("xor_out", {15'h0, ^xor_pins}, {15'h0, xor_out});
    wr(8'h6f, 8'h00);
    chk("xor_en", 16'h0000, {15'h0, xor_tree_enable});
    $display("test mode done");
    run <= 1'b1;
    wait_valid();
    @(posedge mclk);
    #1;
    wait_valid();
    chk("tach_count", 16'h0001, {15'h0, tach_count[0] inside {[38:42]}});
    chk("tach_four", 16'h0001, {15'h0, tach_count[3] inside {[38:42]}});
    @(posedge mclk) high_freq <= 1'b1;
    run <= 1'b0;
    repeat (34000) @(posedge mclk);
    #1;
    chk("tach_plain", 16'h0000, {15'h0, tach_count[0] === 16'hffff});
    @(posedge mclk) high_freq <= 1'b0;
    n = 0;
    while (tach_count[0] !== 16'hffff && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("tach_sat", 16'hffff, tach_count[0]);
    chk("tach_sat4", 16'hffff, tach_count[3]);
    if (n >= 40000) complete_run();
    run <= 1'b1;
    $display("tach test done");
    spin(1'b0);
    @(posedge mclk) start_bit <= 1'b0;
    spin(1'b1);
    @(posedge mclk) start_bit <= 1'b1;
    wr(8'h75, 8'h01);
    spin(1'b1);
    $display("spin-up test done");
    complete_run();
  end
endmodule
